// *** fbr_pkg.sv ***
// Package for the flash bus controller: pin bundles, command codes and timing counts.
package fbr_pkg;

   // Clock period in picoseconds, 10 MHz.
   localparam int CLK_PERIOD_PS = 100000;

   // Reset pulse least width, in ns.
   localparam int RESET_PULSE_MIN_NS = 100;
   localparam int RESET_PULSE_CYC_RAW = (RESET_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RESET_PULSE_CYC = (RESET_PULSE_CYC_RAW < 1) ? 1 : RESET_PULSE_CYC_RAW;

   // Reset completion when idle, in ns; the host waits at least this long.
   localparam int RESET_DONE_NS = 100;
   localparam int RESET_DONE_CYC_RAW = (RESET_DONE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RESET_DONE_CYC = (RESET_DONE_CYC_RAW < 1) ? 1 : RESET_DONE_CYC_RAW;

   // Abort shutdown times, in us, for an erase and for a program.
   localparam int ABORT_ERASE_US = 22;
   localparam int ABORT_PROG_US = 12;
   localparam int ABORT_ERASE_CYC = (ABORT_ERASE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ABORT_PROG_CYC = (ABORT_PROG_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Recovery intervals after reset release, in ns (values not given; plain defaults).
   localparam int READ_RECOVERY_NS = 150;
   localparam int WRITE_RECOVERY_NS = 1000;
   localparam int READ_RECOVERY_CYC = (READ_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Strobe phase lengths of one bus cycle, in clocks.
   localparam int SETUP_CYC = 1;
   localparam int STROBE_CYC = 2;
   localparam int HOLD_CYC = 1;

   // Read-array command and idle-status value.
   localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
   localparam logic [7:0] STATUS_AFTER_RESET = 8'h80;

   // Width of the shared counter.
   localparam int CNT_W = 10;

   // Host request kinds.
   typedef enum logic [1:0] {
      FBR_OP_READ = 2'b00,
      FBR_OP_WRITE = 2'b01,
      FBR_OP_RESET = 2'b10
   } fbr_op_t;

   // Request bundle from the user side.
   typedef struct packed {
      fbr_op_t op;
      logic [21:0] addr;
      logic [15:0] data;
      logic abortErase;
   } fbr_req_t;

   // Control strobes to the flash, all active low.
   typedef struct packed {
      logic resetPowerdown_n;
      logic chipEnable_n;
      logic outputEnable_n;
      logic writeEnable_n;
   } fbr_ctl_t;

endpackage : fbr_pkg

// *** fbr_host.sv ***
// Host-side controller that drives an asynchronous NOR flash through its bus pins.
`timescale 1ns/1ps
module fbr_host (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic reqValid,
   input wire fbr_pkg::fbr_req_t req,
   output logic reqReady,
   output logic rdValid,
   output logic [15:0] rdData,
   output fbr_pkg::fbr_ctl_t flashCtl,
   output logic [21:0] flashAddr,
   output logic [15:0] flashDataOut,
   output logic flashDataOe_n,
   input wire logic [15:0] flashDataIn
);
   import fbr_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_STROBE = 3'b010,
      ST_HOLD = 3'b011,
      ST_RESET = 3'b100
   } fbr_state_t;

   fbr_state_t state;
   fbr_op_t curOp;
   logic [CNT_W-1:0] phaseCnt;
   logic [CNT_W-1:0] readWait;
   logic [CNT_W-1:0] writeWait;
   logic [CNT_W-1:0] next_phaseCnt;

   ////////////////////////////////////////////////////////////////////////////
   // Cycle sequencing.

   // A request is accepted only when the recovery for its kind has elapsed.
   logic canTake;
   always_comb begin
      unique case (req.op)
         FBR_OP_READ: canTake = (readWait == '0);
         FBR_OP_WRITE: canTake = (writeWait == '0);
         default: canTake = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request decode.

   // A request is taken at this edge when the controller is idle and the recovery for its kind has run out.
   logic takeNow;
   assign takeNow = (state == ST_IDLE) && reqValid && canTake;

   // A taken reset request pulls the flash reset pin low from the next cycle on.
   logic takeReset;
   assign takeReset = takeNow && (req.op == FBR_OP_RESET);

   // A taken read or write opens a bus cycle; chip enable falls with the setup phase.
   logic takeCycle;
   assign takeCycle = takeNow && (req.op != FBR_OP_RESET);

   // A taken write turns the data bus round to the host one cycle before write enable falls.
   logic takeWrite;
   assign takeWrite = takeCycle && (req.op == FBR_OP_WRITE);

   // The strobe window spans the setup phase and every strobe cycle but the last.
   // Ending the window one cycle early leaves a full clock of address and data hold
   // after write enable rises, and lets output enable rise before chip enable does.
   logic strobeWindow;
   assign strobeWindow = (state == ST_SETUP) || (state == ST_STROBE && phaseCnt > CNT_W'(1));

   // The reset or abort hold still has cycles left; the pin stays low until the last one.
   logic resetHolding;
   assign resetHolding = (state == ST_RESET) && (phaseCnt > CNT_W'(1));

   // The last strobe cycle of a read, in which the word on the data bus is taken.
   // Output enable is still low at this edge, so the flash is still driving.
   logic readSample;
   assign readSample = (curOp == FBR_OP_READ) && (state == ST_STROBE) && (phaseCnt == CNT_W'(1));

   // Either phase of a bus cycle in which chip enable must be low.
   logic inCycle;
   assign inCycle = (state == ST_SETUP) || (state == ST_STROBE);

   // Phase length loaded on each entry to the setup, strobe, hold or reset state.
   always_comb begin
      next_phaseCnt = '0;
      if (state == ST_IDLE && reqValid && canTake) begin
         if (req.op == FBR_OP_RESET) begin
            if (req.abortErase) begin
               next_phaseCnt = CNT_W'(ABORT_ERASE_CYC);
            end else if (req.data[0]) begin
               next_phaseCnt = CNT_W'(ABORT_PROG_CYC);
            end else begin
               next_phaseCnt = CNT_W'((RESET_PULSE_CYC > RESET_DONE_CYC) ? RESET_PULSE_CYC : RESET_DONE_CYC);
            end
         end else begin
            next_phaseCnt = CNT_W'(SETUP_CYC);
         end
      end else if (state == ST_SETUP) begin
         next_phaseCnt = CNT_W'(STROBE_CYC);
      end else if (state == ST_STROBE) begin
         next_phaseCnt = CNT_W'(HOLD_CYC);
      end
   end

   // State and phase counter.
   // The counter holds the cycles left in the current phase, so every phase ends when it reads one.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_RESET;
         phaseCnt <= CNT_W'(RESET_PULSE_CYC);
         curOp <= FBR_OP_RESET;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (reqValid && canTake) begin
                  curOp <= req.op;
                  phaseCnt <= next_phaseCnt;
                  state <= (req.op == FBR_OP_RESET) ? ST_RESET : ST_SETUP;
               end
            end
            ST_SETUP, ST_STROBE: begin
               if (phaseCnt == CNT_W'(1)) begin
                  phaseCnt <= next_phaseCnt;
                  state <= (state == ST_SETUP) ? ST_STROBE : ST_HOLD;
               end else begin
                  phaseCnt <= phaseCnt - CNT_W'(1);
               end
            end
            ST_HOLD, ST_RESET: begin
               if (phaseCnt <= CNT_W'(1)) begin
                  state <= ST_IDLE;
               end else begin
                  phaseCnt <= phaseCnt - CNT_W'(1);
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Recovery counters start from the end of the reset or shutdown hold.
   // They load in the last hold cycle, the same edge at which the reset pin is released.
   // A request of either kind waits in idle until its own counter reaches zero.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         readWait <= '0;
         writeWait <= '0;
      end else if (state == ST_RESET && phaseCnt <= CNT_W'(1)) begin
         readWait <= CNT_W'(READ_RECOVERY_CYC);
         writeWait <= CNT_W'(WRITE_RECOVERY_CYC);
      end else begin
         if (readWait != '0) readWait <= readWait - CNT_W'(1);
         if (writeWait != '0) writeWait <= writeWait - CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers.

   // Control strobes follow the state; chip enable is high when idle.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         flashCtl <= '{resetPowerdown_n: 1'b0, chipEnable_n: 1'b1, outputEnable_n: 1'b1, writeEnable_n: 1'b1};
      end else begin
         flashCtl.resetPowerdown_n <= !takeReset && !resetHolding;
         flashCtl.chipEnable_n <= !(takeCycle || inCycle);
         flashCtl.outputEnable_n <= !(curOp == FBR_OP_READ && strobeWindow);
         flashCtl.writeEnable_n <= !(curOp == FBR_OP_WRITE && strobeWindow);
      end
   end

   // Address and write data held from acceptance through the hold phase.
   // They load only when a bus cycle is taken, so a reset request leaves them as they were.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         flashAddr <= '0;
         flashDataOut <= '0;
         flashDataOe_n <= 1'b1;
      end else begin
         if (takeCycle) begin
            flashAddr <= req.addr;
            flashDataOut <= req.data;
         end
         flashDataOe_n <= !(takeWrite || (curOp == FBR_OP_WRITE && inCycle));
      end
   end

   // Read data sampled in the last strobe cycle.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rdValid <= 1'b0;
         rdData <= '0;
      end else begin
         rdValid <= readSample;
         if (readSample) begin
            rdData <= flashDataIn;
         end
      end
   end

   // Ready is shown in idle whenever no request is taken that cycle, even while recovery holds a waiting request back.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         reqReady <= 1'b0;
      end else begin
         reqReady <= (state == ST_IDLE) && !(reqValid && canTake);
      end
   end

endmodule : fbr_host

// *** fbr_host_assertions.sv ***
// Port checker for the flash bus controller.
`timescale 1ns/1ps
module fbr_host_assertions import fbr_pkg::*; (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic rdValid,
   input wire fbr_pkg::fbr_ctl_t flashCtl,
   input wire logic [21:0] flashAddr,
   input wire logic [15:0] flashDataOut,
   input wire logic flashDataOe_n
);
   int lowCount;
   wire resetPin_n = flashCtl.resetPowerdown_n;
   wire ce_n = flashCtl.chipEnable_n;
   wire oe_n = flashCtl.outputEnable_n;
   wire we_n = flashCtl.writeEnable_n;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Counts clocks with the flash reset pin low.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) lowCount <= 0;
      else lowCount <= resetPin_n ? 0 : lowCount + 1;
   end
   chk_read_strobes: assert property (!oe_n |-> we_n && !ce_n && resetPin_n)
      else $error("read strobes wrong");
   chk_write_strobes: assert property (!we_n |-> oe_n && !ce_n && resetPin_n)
      else $error("write strobes wrong");
   chk_bus_turn: assert property (!flashDataOe_n |-> oe_n)
      else $error("bus driven during read");
   chk_latch_hold: assert property ($rose(we_n) |-> !flashDataOe_n && $stable(flashAddr) && $stable(flashDataOut))
      else $error("write word moved at latch");
   chk_sys_reset: assert property (disable iff (1'b0) sys_rst ##1 sys_rst |-> !resetPin_n)
      else $error("reset pin high in system reset");
   chk_reset_width: assert property ($rose(resetPin_n) |-> lowCount >= RESET_PULSE_CYC)
      else $error("reset pulse short");
   chk_read_recovery: assert property ($rose(resetPin_n) |-> ce_n [*3])
      else $error("read too soon after reset");
   chk_write_recovery: assert property ($rose(resetPin_n) |-> we_n [*8] ##1 we_n [*4])
      else $error("write too soon after reset");
   chk_read_answer: assert property (rdValid |-> !$past(oe_n) ##1 !rdValid)
      else $error("read answer misplaced");
endmodule : fbr_host_assertions
bind fbr_host fbr_host_assertions fbr_host_assertions_i (.clock(clock), .sys_rst(sys_rst), .rdValid(rdValid),
   .flashCtl(flashCtl), .flashAddr(flashAddr), .flashDataOut(flashDataOut), .flashDataOe_n(flashDataOe_n));

// *** fbr_flash_model.sv ***
// Behavioural model of the flash device on the host pins.
`timescale 1ns/1ps
module fbr_flash_model import fbr_pkg::*; (
   input wire fbr_pkg::fbr_ctl_t ctl,
   input wire logic [21:0] addr,
   input wire logic [15:0] dataIn,
   input wire logic slow,
   output logic [15:0] dataOut,
   output logic dataEn
);
   logic arrayMode = 1'b1;
   logic [7:0] status = 8'h80;
   logic [15:0] lastWord;
   logic drive, enFast, enSlow;
   wire wrStrobe = !ctl.chipEnable_n && !ctl.writeEnable_n && ctl.outputEnable_n && ctl.resetPowerdown_n;
   // Reset returns to array reads with idle status, dropping any operation.
   always @(negedge ctl.resetPowerdown_n) begin
      arrayMode = 1'b1;
      status = STATUS_AFTER_RESET;
   end
   // The word is taken as the write pulse ends.
   // The strobe also falls as the pins leave their unknown power-up state, which is no write.
   always @(negedge wrStrobe) begin
      if (ctl.resetPowerdown_n === 1'b1) begin
         lastWord = dataIn;
         arrayMode = (dataIn === CMD_READ_ARRAY);
      end
   end
   assign drive = ctl.resetPowerdown_n && !ctl.chipEnable_n && !ctl.outputEnable_n && ctl.writeEnable_n;
   assign #10 enFast = drive;
   assign #150 enSlow = drive;
   // Output turns on after the access delay and off at once.
   assign dataEn = drive && (slow ? enSlow : enFast);
   assign dataOut = arrayMode ? (addr[15:0] ^ 16'h3c5a) : {8'h00, status};
endmodule : fbr_flash_model

// *** tb_flash_bus_ops_reset.sv ***
// Self-checking bench for the flash bus controller.
`timescale 1ns/1ps
module tb_flash_bus_ops_reset;
   import fbr_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic reqValid = 1'b0;
   fbr_req_t req = '0;
   logic slow = 1'b0;
   logic rdValid, flashDataOe_n, modelEn, stMode, reqReady;
   logic [15:0] rdData, flashDataOut, modelOut, busLine, got;
   logic [15:0] floatPat = 16'h5555;
   fbr_ctl_t flashCtl;
   logic [21:0] flashAddr;
   int bad_count = 0;
   int total_checks = 0;
   int lowCycles;
   always #50 clock = ~clock;
   // A released bus shows a pattern that flips every cycle.
   always @(posedge clock) floatPat <= ~floatPat;
   assign busLine = modelEn ? modelOut : (!flashDataOe_n ? flashDataOut : floatPat);
   fbr_host fbr_host_i (.clock(clock), .sys_rst(sys_rst), .reqValid(reqValid), .req(req), .reqReady(reqReady),
      .rdValid(rdValid), .rdData(rdData), .flashCtl(flashCtl), .flashAddr(flashAddr),
      .flashDataOut(flashDataOut), .flashDataOe_n(flashDataOe_n), .flashDataIn(busLine));
   fbr_flash_model fbr_flash_model_i (.ctl(flashCtl), .addr(flashAddr), .dataIn(busLine), .slow(slow),
      .dataOut(modelOut), .dataEn(modelEn));
   // Compares one value and counts it.
   task automatic check(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
      end
   endtask : check
   // Holds a request until the strobes move, then waits for idle.
   task automatic do_op(input fbr_op_t op, input logic [21:0] a, input logic [15:0] d, input logic ae);
      int n;
      n = 0;
      got = 'x;
      lowCycles = 0;
      @(negedge clock);
      check(16'(reqReady), 16'h1);
      req = '{op, a, d, ae};
      reqValid = 1'b1;
      while (flashCtl.chipEnable_n && flashCtl.resetPowerdown_n && n < 2000) begin
         @(negedge clock);
         n++;
      end
      reqValid = 1'b0;
      while (!(flashCtl.chipEnable_n && flashCtl.resetPowerdown_n) && n < 2000) begin
         if (rdValid === 1'b1) got = rdData;
         if (!flashCtl.resetPowerdown_n) lowCycles++;
         @(negedge clock);
         n++;
      end
      if (n >= 2000) bad_count++;
   endtask : do_op
   // Expected read word in array or status mode.
   function automatic logic [15:0] expRead(input logic [21:0] a, input logic st);
      return st ? {8'h00, STATUS_AFTER_RESET} : (a[15:0] ^ 16'h3c5a);
   endfunction : expRead
   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test
   // Main sequence of reads, writes and resets.
   initial begin
      logic [21:0] a;
      logic [15:0] d;
      int k;
      void'($urandom(17));
      repeat (6) @(negedge clock);
      sys_rst = 1'b0;
      repeat (4) @(negedge clock);
      stMode = 1'b0;
      for (int t = 0; t < 40; t++) begin
         a = 22'($urandom);
         d = (t % 10 == 1) ? CMD_READ_ARRAY : 16'($urandom);
         slow = 1'($urandom);
         k = (t / 5) % 3;
         case (t % 5)
            1: begin
               do_op(FBR_OP_WRITE, a, d, 1'b0);
               stMode = (d !== CMD_READ_ARRAY);
               check(fbr_flash_model_i.lastWord, d);
            end
            3: begin
               do_op(FBR_OP_RESET, a, {15'h0, k == 1}, k == 2);
               stMode = 1'b0;
               check(16'(lowCycles >= (k == 2 ? ABORT_ERASE_CYC : k == 1 ? ABORT_PROG_CYC : RESET_DONE_CYC)), 16'h1);
            end
            default: begin
               do_op(FBR_OP_READ, a, 16'h0, 1'b0);
               check(got, expRead(a, stMode));
               check(16'(flashAddr[21:16]), 16'(a[21:16]));
            end
         endcase
         $display("test %0d done", t);
      end
      // A system reset in mid-run pulls the reset pin low and brings back array reads.
      a = 22'($urandom);
      do_op(FBR_OP_WRITE, a, 16'h1234, 1'b0);
      check(fbr_flash_model_i.lastWord, 16'h1234);
      @(negedge clock);
      sys_rst = 1'b1;
      repeat (2) @(negedge clock);
      check(16'(flashCtl.resetPowerdown_n), 16'h0);
      sys_rst = 1'b0;
      repeat (2) @(negedge clock);
      do_op(FBR_OP_READ, a, 16'h0, 1'b0);
      check(got, expRead(a, 1'b0));
      $display("test mid-run reset done");
      finish_test();
   end
   // Cuts a hung run short.
   initial begin
      #2000000;
      bad_count++;
      finish_test();
   end
endmodule : tb_flash_bus_ops_reset
